// File: das_map.svh
/*
 * Constants of the driver alarm and step configuration block: register offsets,
 * field positions, reset values, fault codes and timing figures.
 * Assumes a 20 MHz system clock and a byte-addressed Avalon-MM slave.
 */
`ifndef DAS_MAP_SVH
`define DAS_MAP_SVH

`define DAS_CLK_KHZ 20000
`define DAS_BLINK_ON_MS 200
`define DAS_BLINK_OFF_MS 300
`define DAS_BLINK_PAUSE_MS 1500
`define DAS_OVERLOAD_MS 5000

`define DAS_OVERSPEED_RPM 16'h1388
`define DAS_DEV_LIMIT 16'h01F4

`define DAS_SPR_1000 14'h03E8
`define DAS_SPR_10000 14'h2710
`define DAS_SPR_500 14'h01F4
`define DAS_SPR_5000 14'h1388

`define DAS_CODE_OVERLOAD 4'h2
`define DAS_CODE_OVERVOLT 4'h3
`define DAS_CODE_SPEED 4'h4
`define DAS_CODE_OVERSPEED 4'h6
`define DAS_CODE_MEMORY 4'h7
`define DAS_CODE_SENSOR 4'h8
`define DAS_CODE_NONE 4'h0

`define DAS_REG_CTRL 4'h0
`define DAS_REG_STATUS 4'h4
`define DAS_REG_POSITION 4'h8
`define DAS_REG_DEVIATION 4'hC

`define DAS_CTRL_CLEAR 0
`define DAS_CTRL_GEARED 1
`define DAS_CTRL_RESET 1'h0

`define DAS_ST_FAULT_LSB 0
`define DAS_ST_FAULT_MSB 6
`define DAS_ST_ALARM 7
`define DAS_ST_MODE 8
`define DAS_ST_EXCITED 9
`define DAS_ST_GEARED 10
`define DAS_ST_SPR_LSB 16
`define DAS_ST_SPR_MSB 29

`define DAS_FLT_OVERLOAD 0
`define DAS_FLT_OVERVOLT 1
`define DAS_FLT_SPEED 2
`define DAS_FLT_OVERSPEED 3
`define DAS_FLT_MEMORY 4
`define DAS_FLT_SENSOR 5
`define DAS_FLT_FATAL 6

`endif

// File: das_pkg.sv
/*
 * Types shared by the driver alarm and step configuration block.
 * Assumes nothing of its surroundings.
 */
package das_pkg;
    typedef enum logic [1:0] {
        DAS_BL_IDLE,
        DAS_BL_ON,
        DAS_BL_OFF,
        DAS_BL_PAUSE
    } das_blink_state_t;

    typedef logic [6:0] das_fault_vec_t;
endpackage : das_pkg

// File: das_blinker.sv
/*
 * Alarm lamp sequencer: repeats a group of blinks separated by a long dark pause,
 * or holds the lamp steadily lit.
 * Assumes blink_count and steady are synchronous to clk.
 */
`timescale 1ns/1ps
`include "das_map.svh"
module das_blinker
    import das_pkg::*;
#(
    parameter int unsigned ON_CYCLES = 4000000,
    parameter int unsigned OFF_CYCLES = 6000000,
    parameter int unsigned PAUSE_CYCLES = 30000000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] blink_count,
    input wire logic steady,
    output logic lamp
);
    das_blink_state_t state;
    das_blink_state_t next_state;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic [3:0] done;
    logic [3:0] next_done;
    logic next_lamp;

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_done = done;
        case (state)
            DAS_BL_IDLE: begin
                next_timer = 32'h0;
                next_done = 4'h0;
                if (blink_count != `DAS_CODE_NONE) begin
                    next_state = DAS_BL_ON;
                end
            end
            DAS_BL_ON: begin
                next_timer = timer + 32'h1;
                if (timer >= ON_CYCLES - 1) begin
                    next_timer = 32'h0;
                    next_done = done + 4'h1;
                    next_state = DAS_BL_OFF;
                end
            end
            DAS_BL_OFF: begin
                next_timer = timer + 32'h1;
                if (timer >= OFF_CYCLES - 1) begin
                    next_timer = 32'h0;
                    next_state = (done >= blink_count) ? DAS_BL_PAUSE : DAS_BL_ON;
                end
            end
            DAS_BL_PAUSE: begin
                next_timer = timer + 32'h1;
                if (timer >= PAUSE_CYCLES - 1) begin
                    next_state = DAS_BL_IDLE;
                end
            end
            default: begin
                next_state = DAS_BL_IDLE;
            end
        endcase
        if (steady || blink_count == `DAS_CODE_NONE) begin
            next_state = DAS_BL_IDLE;
        end
        next_lamp = steady || (next_state == DAS_BL_ON);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= DAS_BL_IDLE;
            timer <= 32'h0;
            done <= 4'h0;
            lamp <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            done <= next_done;
            lamp <= next_lamp;
        end
    end
endmodule : das_blinker

// File: das_driver_status.sv
/*
 * Status and configuration logic of a closed-loop stepping driver: fault latching,
 * alarm and power lamps, resolution and pulse-mode decoding, deviation tracking,
 * and an Avalon-MM register slave.
 * Assumes all pins are synchronous to clk and that reset_n is released at power-up.
 */
`timescale 1ns/1ps
`include "das_map.svh"
module das_driver_status
    import das_pkg::*;
#(
    parameter int unsigned OVERLOAD_CYCLES = `DAS_OVERLOAD_MS * `DAS_CLK_KHZ,
    parameter int unsigned BLINK_ON_CYCLES = `DAS_BLINK_ON_MS * `DAS_CLK_KHZ,
    parameter int unsigned BLINK_OFF_CYCLES = `DAS_BLINK_OFF_MS * `DAS_CLK_KHZ,
    parameter int unsigned BLINK_PAUSE_CYCLES = `DAS_BLINK_PAUSE_MS * `DAS_CLK_KHZ,
    parameter logic [15:0] DEV_LIMIT = `DAS_DEV_LIMIT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic step_pulse_in,
    input wire logic dir_n_in,
    input wire logic fault_clear_in,
    input wire logic res_mult_in,
    input wire logic de_excite_in,
    input wire logic res_base_500_sw,
    input wire logic res_x10_sw,
    input wire logic dual_pulse_sw,
    input wire logic fb_cw_in,
    input wire logic fb_ccw_in,
    input wire logic over_torque_in,
    input wire logic over_voltage_in,
    input wire logic [15:0] shaft_rpm_in,
    input wire logic memory_fault_in,
    input wire logic cable_present_in,
    input wire logic fatal_error_in,
    output logic step_cw,
    output logic step_ccw,
    output logic winding_enable,
    output logic [13:0] steps_per_rev,
    output logic alarm_out,
    output logic fault_lamp,
    output logic power_lamp
);
    logic cfg_taken;
    logic next_cfg_taken;
    logic base_500;
    logic next_base_500;
    logic x10_sw;
    logic next_x10_sw;
    logic dual_mode;
    logic next_dual_mode;
    logic [13:0] next_steps_per_rev;

    logic pulse_d;
    logic dir_d;
    logic clear_d;
    logic next_step_cw;
    logic next_step_ccw;
    logic [31:0] position;
    logic [31:0] next_position;
    logic [15:0] deviation;
    logic [15:0] next_deviation;
    logic [15:0] dev_abs;

    logic [31:0] ovl_count;
    logic [31:0] next_ovl_count;
    das_fault_vec_t faults;
    das_fault_vec_t next_faults;
    das_fault_vec_t fault_set;
    logic fault_clear;
    logic [3:0] blink_code;
    logic next_alarm_out;
    logic next_winding_enable;

    logic geared;
    logic next_geared;
    logic soft_clear;
    logic next_soft_clear;
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [31:0] status_word;

    // Switches and cable presence are caught once, at the first edge after reset.
    always_comb begin
        next_cfg_taken = 1'b1;
        next_base_500 = base_500;
        next_x10_sw = x10_sw;
        next_dual_mode = dual_mode;
        if (!cfg_taken) begin
            next_base_500 = res_base_500_sw;
            next_x10_sw = res_x10_sw;
            next_dual_mode = dual_pulse_sw;
        end
        if (x10_sw || res_mult_in) begin
            next_steps_per_rev = base_500 ? `DAS_SPR_5000 : `DAS_SPR_10000;
        end else begin
            next_steps_per_rev = base_500 ? `DAS_SPR_500 : `DAS_SPR_1000;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_taken <= 1'b0;
            base_500 <= 1'b0;
            x10_sw <= 1'b0;
            dual_mode <= 1'b0;
            steps_per_rev <= `DAS_SPR_1000;
        end else begin
            cfg_taken <= next_cfg_taken;
            base_500 <= next_base_500;
            x10_sw <= next_x10_sw;
            dual_mode <= next_dual_mode;
            steps_per_rev <= next_steps_per_rev;
        end
    end

    // Command decoding and deviation tracking.
    always_comb begin
        next_step_cw = 1'b0;
        next_step_ccw = 1'b0;
        if (cfg_taken && !de_excite_in) begin
            if (dual_mode) begin
                next_step_cw = step_pulse_in && !pulse_d;
                next_step_ccw = dir_n_in && !dir_d;
            end else if (step_pulse_in && !pulse_d) begin
                next_step_cw = !dir_n_in;
                next_step_ccw = dir_n_in;
            end
        end
        next_position = position;
        next_deviation = deviation;
        if (next_step_cw) begin
            next_position = position + 32'h1;
        end
        if (next_step_ccw) begin
            next_position = position - 32'h1;
        end
        next_deviation = deviation + {15'h0, next_step_cw} - {15'h0, next_step_ccw}
            - {15'h0, fb_cw_in} + {15'h0, fb_ccw_in};
        if (de_excite_in) begin
            next_deviation = 16'h0;
        end
        next_winding_enable = !de_excite_in;
        dev_abs = deviation[15] ? (16'h0 - deviation) : deviation;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_d <= 1'b0;
            dir_d <= 1'b0;
            step_cw <= 1'b0;
            step_ccw <= 1'b0;
            position <= 32'h0;
            deviation <= 16'h0;
            winding_enable <= 1'b0;
        end else begin
            pulse_d <= step_pulse_in;
            dir_d <= dir_n_in;
            step_cw <= next_step_cw;
            step_ccw <= next_step_ccw;
            position <= next_position;
            deviation <= next_deviation;
            winding_enable <= next_winding_enable;
        end
    end

    // Fault detection and latching; a new fault wins over a clear in the same cycle.
    always_comb begin
        next_ovl_count = over_torque_in ? ovl_count : 32'h0;
        if (over_torque_in && ovl_count <= OVERLOAD_CYCLES) begin
            next_ovl_count = ovl_count + 32'h1;
        end
        fault_set = '0;
        fault_set[`DAS_FLT_OVERLOAD] = ovl_count > OVERLOAD_CYCLES;
        fault_set[`DAS_FLT_OVERVOLT] = over_voltage_in;
        fault_set[`DAS_FLT_SPEED] = dev_abs > DEV_LIMIT;
        fault_set[`DAS_FLT_OVERSPEED] = !geared && shaft_rpm_in > `DAS_OVERSPEED_RPM;
        fault_set[`DAS_FLT_MEMORY] = memory_fault_in;
        fault_set[`DAS_FLT_SENSOR] = !cfg_taken && !cable_present_in;
        fault_set[`DAS_FLT_FATAL] = fatal_error_in;
        fault_clear = (fault_clear_in && !clear_d) || soft_clear;
        next_faults = faults;
        if (fault_clear) begin
            next_faults[`DAS_FLT_SENSOR:0] = '0;
        end
        next_faults = next_faults | fault_set;
        next_alarm_out = next_faults != '0;
        if (faults[`DAS_FLT_OVERLOAD]) begin
            blink_code = `DAS_CODE_OVERLOAD;
        end else if (faults[`DAS_FLT_OVERVOLT]) begin
            blink_code = `DAS_CODE_OVERVOLT;
        end else if (faults[`DAS_FLT_SPEED]) begin
            blink_code = `DAS_CODE_SPEED;
        end else if (faults[`DAS_FLT_OVERSPEED]) begin
            blink_code = `DAS_CODE_OVERSPEED;
        end else if (faults[`DAS_FLT_MEMORY]) begin
            blink_code = `DAS_CODE_MEMORY;
        end else if (faults[`DAS_FLT_SENSOR]) begin
            blink_code = `DAS_CODE_SENSOR;
        end else begin
            blink_code = `DAS_CODE_NONE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovl_count <= 32'h0;
            faults <= '0;
            clear_d <= 1'b0;
            alarm_out <= 1'b0;
            power_lamp <= 1'b0;
        end else begin
            ovl_count <= next_ovl_count;
            faults <= next_faults;
            clear_d <= fault_clear_in;
            alarm_out <= next_alarm_out;
            power_lamp <= 1'b1;
        end
    end

    das_blinker #(
        .ON_CYCLES(BLINK_ON_CYCLES),
        .OFF_CYCLES(BLINK_OFF_CYCLES),
        .PAUSE_CYCLES(BLINK_PAUSE_CYCLES)
    ) u_blinker (
        .clk(clk),
        .reset_n(reset_n),
        .blink_count(blink_code),
        .steady(faults[`DAS_FLT_FATAL]),
        .lamp(fault_lamp)
    );

    // Register slave: every access waits exactly one cycle.
    always_comb begin
        status_word = 32'h0;
        status_word[`DAS_ST_FAULT_MSB:`DAS_ST_FAULT_LSB] = faults;
        status_word[`DAS_ST_ALARM] = alarm_out;
        status_word[`DAS_ST_MODE] = dual_mode;
        status_word[`DAS_ST_EXCITED] = winding_enable;
        status_word[`DAS_ST_GEARED] = geared;
        status_word[`DAS_ST_SPR_MSB:`DAS_ST_SPR_LSB] = steps_per_rev;
        next_ack = (avs_read || avs_write) && !ack;
        avs_waitrequest = (avs_read || avs_write) && !ack;
        next_geared = geared;
        next_soft_clear = 1'b0;
        next_readdata = avs_readdata;
        if (next_ack && avs_write && avs_address == `DAS_REG_CTRL && avs_byteenable[0]) begin
            next_geared = avs_writedata[`DAS_CTRL_GEARED];
            next_soft_clear = avs_writedata[`DAS_CTRL_CLEAR];
        end
        if (next_ack && avs_read) begin
            case (avs_address)
                `DAS_REG_CTRL: next_readdata = {30'h0, geared, 1'b0};
                `DAS_REG_STATUS: next_readdata = status_word;
                `DAS_REG_POSITION: next_readdata = position;
                `DAS_REG_DEVIATION: next_readdata = {{16{deviation[15]}}, deviation};
                default: next_readdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
            geared <= `DAS_CTRL_RESET;
            soft_clear <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= next_ack;
            geared <= next_geared;
            soft_clear <= next_soft_clear;
            avs_readdata <= next_readdata;
        end
    end
endmodule : das_driver_status

// File: das_driver_status_monitor.sv
/* Port checker of the driver status block.
   Assumes it is bound onto das_driver_status and sees only its ports. */
`timescale 1ns/1ps
module das_driver_status_monitor #(
    parameter int unsigned OVERLOAD_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic avs_write,
    input wire logic step_pulse_in,
    input wire logic dir_n_in,
    input wire logic fault_clear_in,
    input wire logic de_excite_in,
    input wire logic dual_pulse_sw,
    input wire logic over_torque_in,
    input wire logic fatal_error_in,
    input wire logic step_cw,
    input wire logic step_ccw,
    input wire logic winding_enable,
    input wire logic alarm_out,
    input wire logic fault_lamp,
    input wire logic power_lamp
);
    logic [1:0] up;
    logic [1:0] next_up;
    logic [7:0] ot;
    logic [7:0] next_ot;
    // Counts edges since reset and the length of the present overload.
    always_comb begin
        next_up = (up == 2'h3) ? up : up + 2'h1;
        next_ot = !over_torque_in ? 8'h00 : (ot == 8'hFF) ? ot : ot + 8'h01;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up <= 2'h0;
            ot <= 8'h00;
        end else begin
            up <= next_up;
            ot <= next_ot;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_power_lamp_lit: assert property ($past(reset_n) |-> power_lamp)
        else $error("power lamp dark");
    a_dir_steps: assert property (up == 2'h3 && !dual_pulse_sw && !de_excite_in && $rose(step_pulse_in)
        |=> step_ccw == $past(dir_n_in) && step_cw != $past(dir_n_in)) else $error("wrong step direction");
    a_dual_ccw_step: assert property (up == 2'h3 && dual_pulse_sw && !de_excite_in && $rose(dir_n_in)
        && !step_pulse_in |=> step_ccw && !step_cw) else $error("wrong dual step");
    a_deexcite_off: assert property (de_excite_in |=> !winding_enable && !step_cw && !step_ccw)
        else $error("drive active while de-excited");
    a_fault_held: assert property (alarm_out && !fault_clear_in && !$past(fault_clear_in) && !avs_write
        && !$past(avs_write) |=> alarm_out) else $error("fault dropped without clear");
    a_dark_no_fault: assert property (!alarm_out [*3] |-> !fault_lamp)
        else $error("lamp lit without fault");
    a_overload_trip: assert property (ot == OVERLOAD_CYCLES + 4 |-> alarm_out)
        else $error("overload not flagged");
    a_fatal_steady: assert property ($rose(fatal_error_in) |-> ##3 fault_lamp [*8])
        else $error("fatal lamp not steady");
endmodule : das_driver_status_monitor

bind das_driver_status das_driver_status_monitor #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES)) u_mon (.*);

// File: das_ctrl_model.sv
/* Pulse-train positioning controller model.
   Assumes dual follows the driver's pulse mode switch. */
`timescale 1ns/1ps
module das_ctrl_model (
    input wire logic clk,
    input wire logic dual,
    output logic step_pulse_in,
    output logic dir_n_in,
    output logic fault_clear_in,
    output logic res_mult_in,
    output logic de_excite_in
);
    initial begin
        step_pulse_in = 1'b0;
        dir_n_in = 1'b0;
        fault_clear_in = 1'b0;
        res_mult_in = 1'b0;
        de_excite_in = 1'b0;
    end
    // Direction settles a cycle ahead of each pulse, and a low cycle follows it.
    task automatic steps(input int n, input logic ccw, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            dir_n_in <= ccw && !dual;
            @(posedge clk);
            if (dual && ccw) dir_n_in <= 1'b1;
            else step_pulse_in <= 1'b1;
            @(posedge clk);
            step_pulse_in <= 1'b0;
            dir_n_in <= ccw && !dual;
            repeat (gap) @(posedge clk);
        end
    endtask : steps
    task automatic clear_alarm();
        @(posedge clk);
        fault_clear_in <= 1'b1;
        repeat (2) @(posedge clk);
        fault_clear_in <= 1'b0;
    endtask : clear_alarm
    task automatic level(input logic mult, input logic off);
        @(posedge clk);
        res_mult_in <= mult;
        de_excite_in <= off;
    endtask : level
endmodule : das_ctrl_model

// File: tb_driver_alarm_and_step_config.sv
/* Self-checking bench of the driver status block.
   Assumes the port checker binds itself onto the design. */
`timescale 1ns/1ps
`include "das_map.svh"
module tb_driver_alarm_and_step_config;
    logic clk = 1'b0;
    logic reset_n, avs_read, avs_write, avs_waitrequest, step_pulse_in, dir_n_in, fault_clear_in;
    logic res_mult_in, de_excite_in, res_base_500_sw, res_x10_sw, dual_pulse_sw, fb_cw_in, fb_ccw_in;
    logic over_torque_in, over_voltage_in, memory_fault_in, cable_present_in, fatal_error_in;
    logic step_cw, step_ccw, winding_enable, alarm_out, fault_lamp, power_lamp;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, seed;
    logic [15:0] shaft_rpm_in;
    logic [13:0] steps_per_rev;
    logic [31:0] exp_q[$], mask_q[$];
    int miscompares, samples_checked, ncw, nccw, c0, c1, bad;
    int codes[6] = '{2, 3, 4, 6, 7, 8};
    always #25 clk = ~clk;
    das_driver_status #(.OVERLOAD_CYCLES(20), .BLINK_ON_CYCLES(3), .BLINK_OFF_CYCLES(3), .BLINK_PAUSE_CYCLES(12))
        dut (.*);
    das_ctrl_model ctl (.clk(clk), .dual(dual_pulse_sw), .step_pulse_in(step_pulse_in), .dir_n_in(dir_n_in),
        .fault_clear_in(fault_clear_in), .res_mult_in(res_mult_in), .de_excite_in(de_excite_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [13:0] spr(input logic [2:0] k, input logic m);
        if (k[1] || m) return k[0] ? `DAS_SPR_5000 : `DAS_SPR_10000;
        return k[0] ? `DAS_SPR_500 : `DAS_SPR_1000;
    endfunction : spr
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic stall();
        miscompares++;
        final_report();
    endtask : stall
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) stall();
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        mask_q.push_back(m);
        bus(1'b0, a, 32'h00000000);
    endtask : rd
    task automatic power_up(input logic [2:0] k, input logic cable);
        @(posedge clk);
        reset_n <= 1'b0;
        {dual_pulse_sw, res_x10_sw, res_base_500_sw} <= k;
        cable_present_in <= cable;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("power_lamp", 32'h1, power_lamp);
    endtask : power_up
    // Counts lamp flashes in one group framed by two long dark pauses.
    task automatic blinks(input int e);
        int n, dark = 0, rises = 0;
        logic prev = 1'b0, armed = 1'b0;
        for (n = 0; n < 600; n++) begin
            @(negedge clk);
            if (fault_lamp === 1'b1 && !prev && armed) rises++;
            dark = (fault_lamp === 1'b1) ? 0 : dark + 1;
            prev = (fault_lamp === 1'b1);
            if (dark == 8 && armed && rises > 0) break;
            if (dark == 8) armed = 1'b1;
        end
        if (n == 600) stall();
        check("blinks", e, rises);
    endtask : blinks
    always @(posedge clk) begin
        if (step_cw === 1'b1) ncw++;
        if (step_ccw === 1'b1) nccw++;
    end
    always @(negedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check("readdata", exp_q[0] & mask_q[0], avs_readdata & mask_q[0]);
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
    end
    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, fb_cw_in, fb_ccw_in, over_torque_in, over_voltage_in} = 6'h00;
        {memory_fault_in, fatal_error_in, res_base_500_sw, res_x10_sw, dual_pulse_sw} = 5'h00;
        cable_present_in = 1'b1;
        avs_address = 4'h0;
        avs_byteenable = 4'hF;
        avs_writedata = 32'h00000000;
        shaft_rpm_in = 16'h0000;
        seed = 32'h0C2DE9CB;
        for (int k = 0; k < 8; k++) begin
            power_up(k[2:0], 1'b1);
            for (int m = 0; m < 2; m++) begin
                ctl.level(m[0], 1'b0);
                rd(4'h4, {2'h0, spr(k[2:0], m[0]), 7'h00, k[2], 8'h00}, 32'h3FFF0100);
                check("steps_per_rev", {18'h0, spr(k[2:0], m[0])}, {18'h0, steps_per_rev});
            end
            if (k[1:0] == 2'h0) begin
                c0 = ncw;
                c1 = nccw;
                ctl.steps(3, 1'b0, seed[1:0]);
                seed = lfsr(seed);
                ctl.steps(2, 1'b1, 0);
                ctl.level(1'b0, 1'b1);
                repeat (2) @(posedge clk);
                check("step_cw", c0 + 3, ncw);
                check("step_ccw", c1 + 2, nccw);
                check("winding_enable", 32'h0, winding_enable);
                rd(4'hC, 32'h00000000, 32'hFFFFFFFF);
                rd(4'h8, 32'h00000001, 32'hFFFFFFFF);
            end
        end
        power_up(3'h0, 1'b1);
        for (int f = 0; f < 6; f++) begin
            @(posedge clk);
            case (f)
                0: over_torque_in <= 1'b1;
                1: over_voltage_in <= 1'b1;
                3: shaft_rpm_in <= 16'h1389;
                4: memory_fault_in <= 1'b1;
                5: power_up(3'h0, 1'b0);
                default: ctl.steps(502, 1'b0, 0);
            endcase
            repeat (30) @(posedge clk);
            {over_torque_in, over_voltage_in, memory_fault_in} <= 3'h0;
            shaft_rpm_in <= seed[15:0] % 16'h1388;
            seed = lfsr(seed);
            blinks(codes[f]);
            ctl.level(1'b0, 1'b1);
            ctl.clear_alarm();
            ctl.level(1'b0, 1'b0);
            repeat (2) @(posedge clk);
            check("alarm_out", 32'h0, alarm_out);
        end
        bus(1'b1, 4'h0, 32'h00000002);
        shaft_rpm_in <= 16'hFFFF;
        repeat (5) @(posedge clk);
        check("alarm_out", 32'h0, alarm_out);
        shaft_rpm_in <= 16'h1388;
        bus(1'b1, 4'h0, 32'h00000000);
        repeat (5) @(posedge clk);
        check("alarm_out", 32'h0, alarm_out);
        shaft_rpm_in <= 16'h1389;
        repeat (5) @(posedge clk);
        check("alarm_out", 32'h1, alarm_out);
        shaft_rpm_in <= 16'h0000;
        bus(1'b1, 4'h0, 32'h00000001);
        repeat (3) @(posedge clk);
        check("alarm_out", 32'h0, alarm_out);
        rd(4'h0, 32'h00000000, 32'h00000003);
        bus(1'b1, 4'h2, seed);
        rd(4'h2, 32'h00000000, 32'hFFFFFFFF);
        fatal_error_in <= 1'b1;
        @(posedge clk);
        fatal_error_in <= 1'b0;
        ctl.clear_alarm();
        repeat (4) @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (fault_lamp !== 1'b1) bad++;
        end
        check("steady_lamp", 32'h0, bad);
        check("alarm_out", 32'h1, alarm_out);
        final_report();
    end
endmodule : tb_driver_alarm_and_step_config
